// ### verilog/oag_top.sv
// Operand address generator: effective address, register selection and bit unit.
`timescale 1ns/1ns
module oag_top
    import oag_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Decoded instruction
    input wire logic instr_valid,
    input wire oag_instr_t instr,
    // Register file and segment view
    input wire oag_regs_t regs,
    input wire oag_segs_t segs,
    // Memory data returned for the branch fetch and the bit unit
    input wire logic mem_valid,
    input wire logic [15:0] mem_data,
    // Address and operand outputs
    output logic addr_valid,
    output logic [15:0] effective_addr,
    output logic [19:0] physical_addr,
    output logic [1:0] seg_select,
    output logic [15:0] operand_value,
    output logic [2:0] reg_select,
    output logic reg_is_word,
    output logic reg_high_half,
    output logic mem_access,
    // Pointer and count writeback
    output logic ptr_write,
    output logic [2:0] ptr_reg,
    output logic [15:0] ptr_value,
    output logic count_write,
    output logic [15:0] count_value,
    output logic repeat_done,
    // Bit unit and field length
    output logic [15:0] bit_result,
    output logic bit_value,
    output logic [3:0] field_length,
    // Branch target
    output logic pc_load,
    output logic [15:0] program_counter
);

    ////////////////////////////////////////////////////////////////////////////
    // Combinational decode.

    logic [15:0] disp;
    logic [15:0] base_term;
    logic [15:0] index_term;
    logic [15:0] ea;
    logic [1:0] seg_sel;
    logic [15:0] seg_base;
    logic [15:0] word_reg;
    logic [7:0] byte_reg;
    logic [15:0] step;
    logic [3:0] bit_num;
    logic [15:0] bit_res;
    logic bit_val;
    logic is_mem;

    function automatic logic [15:0] pick_word(input oag_regs_t r, input logic [2:0] sel);
        case (sel)
            OAG_REG_ACC: pick_word = r.accumulator_full;
            OAG_REG_COUNT: pick_word = r.count_word;
            OAG_REG_DATA: pick_word = r.data_general;
            OAG_REG_BASE_GEN: pick_word = r.base_general;
            OAG_REG_STACK_PTR: pick_word = r.stack_pointer;
            OAG_REG_BASE_PTR: pick_word = r.base_pointer;
            OAG_REG_SRC_IDX: pick_word = r.source_index;
            default: pick_word = r.destination_index;
        endcase
    endfunction

    always_comb
    begin
        // Byte fields 0-3 are low halves, 4-7 the high halves of the same four.
        word_reg = pick_word(regs, instr.reg_field);
        byte_reg = 8'(pick_word(regs, {1'b0, instr.reg_field[1:0]})
                      >> {instr.reg_field[2], 3'h0});
        // Short displacement is sign-extended before any sum.
        case (instr.form)
            OAG_FORM_DISP8: disp = {{8{instr.disp_lo[7]}}, instr.disp_lo};
            OAG_FORM_DISP16: disp = {instr.disp_hi, instr.disp_lo};
            default: disp = OAG_WORD_RESET;
        endcase
        base_term = OAG_WORD_RESET;
        index_term = OAG_WORD_RESET;
        seg_sel = OAG_SEG_DATA_A;
        is_mem = 1'b0;
        ea = OAG_WORD_RESET;
        case (instr.mode)
            OAG_MODE_MEMORY:
            begin
                is_mem = 1'b1;
                case (instr.comb)
                    3'h0:
                    begin
                        base_term = regs.base_general;
                        index_term = regs.source_index;
                    end
                    3'h1:
                    begin
                        base_term = regs.base_general;
                        index_term = regs.destination_index;
                    end
                    3'h2:
                    begin
                        base_term = regs.base_pointer;
                        index_term = regs.source_index;
                        seg_sel = OAG_SEG_STACK;
                    end
                    3'h3:
                    begin
                        base_term = regs.base_pointer;
                        index_term = regs.destination_index;
                        seg_sel = OAG_SEG_STACK;
                    end
                    3'h4: index_term = regs.source_index;
                    3'h5: index_term = regs.destination_index;
                    3'h6:
                    begin
                        if (instr.form != OAG_FORM_NO_DISP)
                        begin
                            base_term = regs.base_pointer;
                            seg_sel = OAG_SEG_STACK;
                        end
                    end
                    default: base_term = regs.base_general;
                endcase
                if (instr.comb == OAG_COMB_DIRECT && instr.form == OAG_FORM_NO_DISP)
                begin
                    ea = {instr.disp_hi, instr.disp_lo};
                end
                else
                begin
                    ea = base_term + index_term + disp;
                end
                if (instr.seg_override)
                begin
                    seg_sel = instr.override_seg;
                end
            end
            OAG_MODE_BRANCH_IDX:
            begin
                is_mem = 1'b1;
                ea = (instr.reg_field[0] ? regs.destination_index : regs.source_index)
                     + disp;
            end
            OAG_MODE_BLOCK_SRC:
            begin
                is_mem = 1'b1;
                ea = regs.source_index;
                if (instr.seg_override)
                begin
                    seg_sel = instr.override_seg;
                end
            end
            OAG_MODE_BLOCK_DST:
            begin
                is_mem = 1'b1;
                ea = regs.destination_index;
                seg_sel = OAG_SEG_DATA_B;
            end
            default: ea = OAG_WORD_RESET;
        endcase
        if (instr.mode == OAG_MODE_SEGREG)
        begin
            seg_sel = instr.seg_field;
        end
        case (seg_sel)
            OAG_SEG_PROGRAM: seg_base = segs.program_segment;
            OAG_SEG_STACK: seg_base = segs.stack_segment;
            OAG_SEG_DATA_A: seg_base = segs.data_segment_a;
            default: seg_base = segs.data_segment_b;
        endcase
        step = instr.size_word ? OAG_STEP_WORD : OAG_STEP_BYTE;
        bit_num = (instr.mode == OAG_MODE_BIT_COUNT) ? regs.count_word[3:0]
                                                     : instr.imm_bits;
    end

    oag_bit_unit u_bit
    (
        .operand(instr.form == OAG_FORM_REG ? (instr.size_word ? word_reg : {8'h00, byte_reg})
                                            : mem_data),
        .size_word(instr.size_word),
        .bit_number(bit_num),
        .bitop(instr.bitop),
        .result(bit_res),
        .bit_value(bit_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs, one cycle after the instruction is offered.

    logic addr_valid_ff, nxt_addr_valid;
    logic [15:0] ea_ff, nxt_ea;
    logic [19:0] phys_ff, nxt_phys;
    logic [1:0] seg_ff, nxt_seg;
    logic [15:0] operand_ff, nxt_operand;
    logic [2:0] reg_sel_ff, nxt_reg_sel;
    logic reg_word_ff, nxt_reg_word;
    logic reg_high_ff, nxt_reg_high;
    logic mem_ff, nxt_mem;
    logic ptr_write_ff, nxt_ptr_write;
    logic [2:0] ptr_reg_ff, nxt_ptr_reg;
    logic [15:0] ptr_value_ff, nxt_ptr_value;
    logic count_write_ff, nxt_count_write;
    logic [15:0] count_value_ff, nxt_count_value;
    logic repeat_done_ff, nxt_repeat_done;
    logic [15:0] bit_result_ff, nxt_bit_result;
    logic bit_value_ff, nxt_bit_value;
    logic [3:0] field_len_ff, nxt_field_len;

    always_comb
    begin
        nxt_addr_valid = instr_valid && is_mem;
        nxt_ea = is_mem ? ea : ea_ff;
        // Segment times sixteen plus unsigned offset; the carry past 20 bits drops.
        nxt_phys = is_mem ? ({4'h0, seg_base} << OAG_SEG_SHIFT) + {4'h0, ea}
                          : phys_ff;
        nxt_seg = seg_sel;
        nxt_operand = operand_ff;
        nxt_reg_sel = {instr.size_word & instr.reg_field[2], instr.reg_field[1:0]};
        nxt_reg_word = instr.size_word;
        nxt_reg_high = !instr.size_word && instr.reg_field[2];
        nxt_mem = instr_valid && is_mem;
        nxt_ptr_write = 1'b0;
        nxt_ptr_reg = ptr_reg_ff;
        nxt_ptr_value = ptr_value_ff;
        nxt_count_write = 1'b0;
        nxt_count_value = count_value_ff;
        nxt_repeat_done = 1'b0;
        nxt_bit_result = bit_result_ff;
        nxt_bit_value = bit_value_ff;
        nxt_field_len = field_len_ff;
        if (instr_valid)
        begin
            case (instr.mode)
                OAG_MODE_REGISTER:
                    nxt_operand = instr.size_word ? word_reg : {8'h00, byte_reg};
                OAG_MODE_SEGREG:
                    nxt_operand = seg_base;
                OAG_MODE_IMMEDIATE:
                    nxt_operand = instr.size_word ? {instr.imm_hi, instr.imm_lo}
                                                  : {8'h00, instr.imm_lo};
                OAG_MODE_FIELD_LEN:
                    nxt_field_len = instr.imm_bits;
                OAG_MODE_BIT_IMM, OAG_MODE_BIT_COUNT:
                begin
                    nxt_bit_result = bit_res;
                    nxt_bit_value = bit_val;
                end
                OAG_MODE_BLOCK_SRC, OAG_MODE_BLOCK_DST:
                begin
                    nxt_ptr_write = 1'b1;
                    nxt_ptr_reg = (instr.mode == OAG_MODE_BLOCK_SRC) ? OAG_REG_SRC_IDX
                                                                     : OAG_REG_DST_IDX;
                    nxt_ptr_value = instr.step_down ? ea - step : ea + step;
                    if (instr.repeat_op)
                    begin
                        nxt_count_write = 1'b1;
                        nxt_count_value = regs.count_word - 16'h0001;
                        nxt_repeat_done = (regs.count_word == 16'h0001);
                    end
                end
                default: nxt_operand = operand_ff;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            addr_valid_ff <= 1'b0;
            ea_ff <= OAG_WORD_RESET;
            phys_ff <= OAG_PHYS_RESET;
            seg_ff <= OAG_SEG_DATA_A;
            operand_ff <= OAG_WORD_RESET;
            reg_sel_ff <= OAG_REG_ACC;
            reg_word_ff <= 1'b0;
            reg_high_ff <= 1'b0;
            mem_ff <= 1'b0;
            ptr_write_ff <= 1'b0;
            ptr_reg_ff <= OAG_REG_SRC_IDX;
            ptr_value_ff <= OAG_WORD_RESET;
            count_write_ff <= 1'b0;
            count_value_ff <= OAG_WORD_RESET;
            repeat_done_ff <= 1'b0;
            bit_result_ff <= OAG_WORD_RESET;
            bit_value_ff <= 1'b0;
            field_len_ff <= 4'h0;
        end
        else
        begin
            addr_valid_ff <= nxt_addr_valid;
            ea_ff <= nxt_ea;
            phys_ff <= nxt_phys;
            seg_ff <= nxt_seg;
            operand_ff <= nxt_operand;
            reg_sel_ff <= nxt_reg_sel;
            reg_word_ff <= nxt_reg_word;
            reg_high_ff <= nxt_reg_high;
            mem_ff <= nxt_mem;
            ptr_write_ff <= nxt_ptr_write;
            ptr_reg_ff <= nxt_ptr_reg;
            ptr_value_ff <= nxt_ptr_value;
            count_write_ff <= nxt_count_write;
            count_value_ff <= nxt_count_value;
            repeat_done_ff <= nxt_repeat_done;
            bit_result_ff <= nxt_bit_result;
            bit_value_ff <= nxt_bit_value;
            field_len_ff <= nxt_field_len;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indexed branch: wait for the memory word, then load the program counter.

    oag_br_state_t br_ff, nxt_br;
    logic [15:0] pc_ff, nxt_pc;
    logic pc_load_ff, nxt_pc_load;

    always_comb
    begin
        nxt_br = br_ff;
        nxt_pc = pc_ff;
        nxt_pc_load = 1'b0;
        case (br_ff)
            OAG_BR_IDLE:
                if (instr_valid && instr.mode == OAG_MODE_BRANCH_IDX)
                begin
                    nxt_br = OAG_BR_WAIT;
                end
            OAG_BR_WAIT:
                if (mem_valid)
                begin
                    nxt_pc = mem_data;
                    nxt_pc_load = 1'b1;
                    nxt_br = OAG_BR_LOAD;
                end
            OAG_BR_LOAD:
                nxt_br = OAG_BR_IDLE;
            default:
                nxt_br = OAG_BR_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            br_ff <= OAG_BR_IDLE;
            pc_ff <= OAG_WORD_RESET;
            pc_load_ff <= 1'b0;
        end
        else
        begin
            br_ff <= nxt_br;
            pc_ff <= nxt_pc;
            pc_load_ff <= nxt_pc_load;
        end
    end

    // Timing assumes bytes are already prefetched: decode, address and answer in one cycle.
    assign addr_valid = addr_valid_ff;
    assign effective_addr = ea_ff;
    assign physical_addr = phys_ff;
    assign seg_select = seg_ff;
    assign operand_value = operand_ff;
    assign reg_select = reg_sel_ff;
    assign reg_is_word = reg_word_ff;
    assign reg_high_half = reg_high_ff;
    assign mem_access = mem_ff;
    assign ptr_write = ptr_write_ff;
    assign ptr_reg = ptr_reg_ff;
    assign ptr_value = ptr_value_ff;
    assign count_write = count_write_ff;
    assign count_value = count_value_ff;
    assign repeat_done = repeat_done_ff;
    assign bit_result = bit_result_ff;
    assign bit_value = bit_value_ff;
    assign field_length = field_len_ff;
    assign pc_load = pc_load_ff;
    assign program_counter = pc_ff;

endmodule

// ### verilog/oag_pkg.sv
// Package with constants and carrier types of the operand address generator.
package oag_pkg;

    localparam logic [1:0] OAG_SEG_PROGRAM = 2'h0;
    localparam logic [1:0] OAG_SEG_STACK = 2'h1;
    localparam logic [1:0] OAG_SEG_DATA_A = 2'h2;
    localparam logic [1:0] OAG_SEG_DATA_B = 2'h3;
    localparam logic [2:0] OAG_REG_ACC = 3'h0;
    localparam logic [2:0] OAG_REG_COUNT = 3'h1;
    localparam logic [2:0] OAG_REG_DATA = 3'h2;
    localparam logic [2:0] OAG_REG_BASE_GEN = 3'h3;
    localparam logic [2:0] OAG_REG_STACK_PTR = 3'h4;
    localparam logic [2:0] OAG_REG_BASE_PTR = 3'h5;
    localparam logic [2:0] OAG_REG_SRC_IDX = 3'h6;
    localparam logic [2:0] OAG_REG_DST_IDX = 3'h7;
    localparam logic [1:0] OAG_FORM_NO_DISP = 2'h0;
    localparam logic [1:0] OAG_FORM_DISP8 = 2'h1;
    localparam logic [1:0] OAG_FORM_DISP16 = 2'h2;
    localparam logic [1:0] OAG_FORM_REG = 2'h3;
    localparam logic [2:0] OAG_COMB_DIRECT = 3'h6;
    localparam logic [15:0] OAG_STEP_BYTE = 16'h0001;
    localparam logic [15:0] OAG_STEP_WORD = 16'h0002;
    localparam logic [15:0] OAG_WORD_RESET = 16'h0000;
    localparam logic [19:0] OAG_PHYS_RESET = 20'h00000;
    localparam logic [3:0] OAG_SEG_SHIFT = 4'h4;
    localparam int OAG_PIPE_CYCLES = 1;

    typedef enum logic [3:0] {
        OAG_MODE_REGISTER,
        OAG_MODE_SEGREG,
        OAG_MODE_IMMEDIATE,
        OAG_MODE_MEMORY,
        OAG_MODE_BLOCK_SRC,
        OAG_MODE_BLOCK_DST,
        OAG_MODE_BIT_IMM,
        OAG_MODE_BIT_COUNT,
        OAG_MODE_FIELD_LEN,
        OAG_MODE_BRANCH_IDX
    } oag_mode_t;

    typedef enum logic [1:0] {
        OAG_BIT_TEST,
        OAG_BIT_SET,
        OAG_BIT_CLEAR,
        OAG_BIT_INVERT
    } oag_bitop_t;

    typedef enum logic [1:0] {
        OAG_BR_IDLE,
        OAG_BR_WAIT,
        OAG_BR_LOAD
    } oag_br_state_t;

    typedef struct packed {
        oag_mode_t mode;
        logic size_word;
        logic [2:0] reg_field;
        logic [1:0] seg_field;
        logic [1:0] form;
        logic [2:0] comb;
        logic seg_override;
        logic [1:0] override_seg;
        logic [7:0] disp_lo;
        logic [7:0] disp_hi;
        logic [7:0] imm_lo;
        logic [7:0] imm_hi;
        logic [3:0] imm_bits;
        logic step_down;
        logic repeat_op;
        oag_bitop_t bitop;
    } oag_instr_t;

    typedef struct packed {
        logic [15:0] accumulator_full;
        logic [15:0] count_word;
        logic [15:0] data_general;
        logic [15:0] base_general;
        logic [15:0] stack_pointer;
        logic [15:0] base_pointer;
        logic [15:0] source_index;
        logic [15:0] destination_index;
    } oag_regs_t;

    typedef struct packed {
        logic [15:0] program_segment;
        logic [15:0] stack_segment;
        logic [15:0] data_segment_a;
        logic [15:0] data_segment_b;
    } oag_segs_t;

endpackage

// ### verilog/oag_bit_unit.sv
// Single-bit test, set, clear and invert on a byte or word operand.
`timescale 1ns/1ns
module oag_bit_unit
    import oag_pkg::*;
(
    // Operand and selection
    input wire logic [15:0] operand,
    input wire logic size_word,
    input wire logic [3:0] bit_number,
    input wire oag_bitop_t bitop,
    // Result
    output logic [15:0] result,
    output logic bit_value
);

    logic [15:0] mask;

    always_comb
    begin
        // A byte operand only honours three bits of the number.
        mask = 16'h0001 << (size_word ? bit_number : {1'b0, bit_number[2:0]});
        bit_value = |(operand & mask);
        case (bitop)
            OAG_BIT_SET: result = operand | mask;
            OAG_BIT_CLEAR: result = operand & ~mask;
            OAG_BIT_INVERT: result = operand ^ mask;
            default: result = operand;
        endcase
        if (!size_word)
        begin
            result[15:8] = operand[15:8];
        end
    end

endmodule

// ### bench/oag_chk.sv
// Port-level assertions for the operand address generator.
`timescale 1ns/1ns
module oag_chk
    import oag_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Inputs watched
    input wire logic instr_valid,
    input wire oag_instr_t instr,
    input wire oag_regs_t regs,
    input wire oag_segs_t segs,
    input wire logic [15:0] mem_data,
    // Outputs watched
    input wire logic addr_valid,
    input wire logic [15:0] effective_addr,
    input wire logic [19:0] physical_addr,
    input wire logic [1:0] seg_select,
    input wire logic ptr_write,
    input wire logic [2:0] ptr_reg,
    input wire logic [15:0] ptr_value,
    input wire logic [15:0] count_value,
    input wire logic repeat_done,
    input wire logic [15:0] bit_result,
    input wire logic [3:0] field_length,
    input wire logic pc_load,
    input wire logic [15:0] program_counter
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    logic [15:0] seg_now;
    logic [15:0] ptr_src;
    logic [15:0] stp;
    logic is_blk;
    logic is_dst;
    assign seg_now = segs[16 * (3 - seg_select) +: 16];
    assign is_dst = instr.mode == OAG_MODE_BLOCK_DST;
    assign is_blk = instr_valid && (is_dst || instr.mode == OAG_MODE_BLOCK_SRC);
    assign ptr_src = is_dst ? regs.destination_index : regs.source_index;
    assign stp = instr.size_word ? OAG_STEP_WORD : OAG_STEP_BYTE;
    ////////////////////////////////////////////////////////////////////////////////
    mem_pulse_a: assert property (
        instr_valid && instr.mode == OAG_MODE_MEMORY |=> addr_valid)
        else $error("no address pulse");
    phys_sum_a: assert property (
        addr_valid |-> physical_addr == {seg_now, 4'h0} + {4'h0, effective_addr})
        else $error("bad physical address");
    direct_off_a: assert property (
        instr_valid && instr.mode == OAG_MODE_MEMORY && instr.form == OAG_FORM_NO_DISP
        && instr.comb == OAG_COMB_DIRECT
        |=> effective_addr == {$past(instr.disp_hi), $past(instr.disp_lo)})
        else $error("bad direct offset");
    stack_dflt_a: assert property (
        instr_valid && instr.mode == OAG_MODE_MEMORY && !instr.seg_override
        && instr.form == OAG_FORM_DISP8 && instr.comb == OAG_COMB_DIRECT
        |=> seg_select == OAG_SEG_STACK)
        else $error("base pointer not on stack segment");
    ptr_step_a: assert property (
        is_blk |=> ptr_write && ptr_reg == ($past(is_dst) ? 3'h7 : 3'h6)
        && ptr_value == $past(instr.step_down ? ptr_src - stp : ptr_src + stp))
        else $error("bad pointer step");
    rep_count_a: assert property (
        is_blk && instr.repeat_op |=> count_value == $past(regs.count_word) - 16'h0001
        && repeat_done == ($past(regs.count_word) == 16'h0001))
        else $error("bad repeat count");
    field_len_a: assert property (
        instr_valid && instr.mode == OAG_MODE_FIELD_LEN
        |=> field_length == $past(instr.imm_bits))
        else $error("bad field length");
    bit_keep_a: assert property (
        instr_valid && instr.mode == OAG_MODE_BIT_IMM && instr.size_word
        && instr.form != OAG_FORM_REG |=> ((bit_result ^ $past(mem_data))
        & ~(16'h0001 << $past(instr.imm_bits))) == 16'h0000)
        else $error("unselected bit changed");
    pc_fetch_a: assert property (
        pc_load |-> program_counter == $past(mem_data))
        else $error("bad branch target");
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the operand address generator.
`timescale 1ns/1ns
module tb_top
    import oag_pkg::*;
;
    logic clk, reset, instr_valid, mem_valid;
    oag_instr_t instr;
    oag_regs_t regs;
    oag_segs_t segs;
    logic [15:0] mem_data, effective_addr, operand_value, ptr_value, count_value;
    logic [15:0] bit_result, program_counter;
    logic [19:0] physical_addr;
    logic [1:0] seg_select;
    logic [2:0] reg_select, ptr_reg;
    logic [3:0] field_length;
    logic addr_valid, reg_is_word, reg_high_half, mem_access, ptr_write, count_write;
    logic repeat_done, bit_value, pc_load;
    int err_count, n_tests, cyc;
    oag_top dut_u (.*);
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // The cycle ceiling is far above the roughly 130 cycles the tests need.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            end_of_test;
        end
    end
    function automatic oag_instr_t mk(oag_mode_t m, logic w, logic [2:0] r, logic [1:0] f,
        logic [15:0] d);
        oag_instr_t i;
        i = '0;
        i.mode = m;
        i.size_word = w;
        i.reg_field = r;
        i.comb = r;
        i.seg_field = r[1:0];
        i.form = f;
        {i.disp_hi, i.disp_lo} = d;
        {i.imm_hi, i.imm_lo} = d;
        i.imm_bits = d[3:0];
        return i;
    endfunction
    function automatic logic [15:0] segval(int s);
        return segs[16 * (3 - s) +: 16];
    endfunction
    task automatic issue(input oag_instr_t i);
        @(negedge clk);
        instr = i;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_mem(logic [2:0] r, logic [1:0] f, logic [15:0] d, logic o,
        logic [15:0] ea, int sg);
        oag_instr_t i;
        i = mk(OAG_MODE_MEMORY, 1'b1, r, f, d);
        i.seg_override = o;
        i.override_seg = OAG_SEG_DATA_B;
        issue(i);
        cmp({addr_valid, mem_access}, 2'h3);
        cmp(effective_addr, ea);
        cmp(seg_select, sg[1:0]);
        cmp(physical_addr, {segval(sg), 4'h0} + {4'h0, ea});
    endtask
    task automatic t_blk(oag_mode_t m, logic w, logic dn, logic [15:0] cnt);
        oag_instr_t i;
        logic [15:0] b;
        regs.count_word = cnt;
        i = mk(m, w, 3'h0, 2'h0, 16'h0000);
        i.step_down = dn;
        i.repeat_op = 1'b1;
        b = (m == OAG_MODE_BLOCK_DST) ? regs.destination_index : regs.source_index;
        b = dn ? b - (w ? 16'h0002 : 16'h0001) : b + (w ? 16'h0002 : 16'h0001);
        issue(i);
        cmp({ptr_write, ptr_reg}, {1'b1, (m == OAG_MODE_BLOCK_DST) ? 3'h7 : 3'h6});
        cmp(ptr_value, b);
        cmp({count_write, count_value, repeat_done},
            {1'b1, cnt - 16'h0001, cnt == 1});
    endtask
    task automatic t_bit(oag_mode_t m, logic w, int op, logic [15:0] v);
        oag_instr_t i;
        logic [3:0] s;
        logic [15:0] k;
        mem_data = v;
        i = mk(m, w, 3'h0, 2'h0, 16'h000b);
        i.bitop = oag_bitop_t'(op);
        s = (m == OAG_MODE_BIT_COUNT) ? regs.count_word[3:0] : 4'hb;
        s[3] = s[3] & w;
        k = 16'h0001 << s;
        issue(i);
        cmp(bit_value, v[s]);
        cmp(bit_result, op == 0 ? v : op == 1 ? v | k : op == 2 ? v & ~k : v ^ k);
    endtask
    task automatic t_branch(logic dst, logic [15:0] word);
        issue(mk(OAG_MODE_BRANCH_IDX, 1'b1, {2'h0, dst}, OAG_FORM_DISP8, 16'h00f4));
        cmp({addr_valid, effective_addr}, {1'b1, dst ? 16'hfff2 : 16'h02f4});
        mem_valid = 1'b1;
        mem_data = word;
        @(negedge clk);
        mem_valid = 1'b0;
        cmp({pc_load, program_counter}, {1'b1, word});
        @(negedge clk);
    endtask
    task automatic t_decode(int n);
        issue(mk(OAG_MODE_REGISTER, n[3], n[2:0], OAG_FORM_REG, 16'h0000));
        cmp(reg_is_word, n[3]);
        cmp({reg_select, reg_high_half},
            n[3] ? {n[2:0], 1'b0} : {1'b0, n[1:0], n[2]});
        cmp(operand_value, n[3] ? regs[16 * (7 - n[2:0]) +: 16]
            : regs[16 * (7 - n[1:0]) + 8 * n[2] +: 8]);
        issue(mk(OAG_MODE_FIELD_LEN, 1'b0, 3'h0, 2'h0, 16'(n)));
        cmp(field_length, n[3:0]);
        if (n < 4)
        begin
            issue(mk(OAG_MODE_SEGREG, 1'b1, n[2:0], 2'h0, 16'h0000));
            cmp(operand_value, segval(n));
            regs.count_word = 16'h000e;
            t_bit(n[0] ? OAG_MODE_BIT_COUNT : OAG_MODE_BIT_IMM, 1'b1, n, 16'h5a5a);
            t_bit(n[0] ? OAG_MODE_BIT_IMM : OAG_MODE_BIT_COUNT, 1'b0, n, 16'h00a5);
        end
    endtask
    task automatic t_imm;
        issue(mk(OAG_MODE_IMMEDIATE, 1'b1, 3'h0, 2'h0, 16'hbeef));
        cmp(operand_value, 16'hbeef);
        issue(mk(OAG_MODE_IMMEDIATE, 1'b0, 3'h0, 2'h0, 16'h1281));
        cmp(operand_value, 16'h0081);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {instr_valid, mem_valid, mem_data, instr} = '0;
        reset = 1'b1;
        regs = {48'h0, 16'h1000, 16'h0000, 16'h2000, 16'h0300, 16'hfffe};
        segs = {16'h1111, 16'h2222, 16'h3333, 16'h4444};
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        cmp({seg_select, ptr_reg}, {2'h2, 3'h6});
        for (int n = 0; n < 16; n++)
        begin
            t_decode(n);
        end
        t_imm;
        t_mem(3'h6, 2'h0, 16'h1234, 1'b0, 16'h1234, 2);
        t_mem(3'h4, 2'h0, 16'h0000, 1'b0, 16'h0300, 2);
        t_mem(3'h5, 2'h0, 16'h0000, 1'b0, 16'hfffe, 2);
        t_mem(3'h7, 2'h0, 16'h0000, 1'b0, 16'h1000, 2);
        t_mem(3'h4, 2'h1, 16'h00f0, 1'b0, 16'h02f0, 2);
        t_mem(3'h5, 2'h2, 16'h0020, 1'b0, 16'h001e, 2);
        t_mem(3'h6, 2'h1, 16'h0004, 1'b0, 16'h2004, 1);
        t_mem(3'h7, 2'h2, 16'h1000, 1'b0, 16'h2000, 2);
        t_mem(3'h0, 2'h0, 16'h0000, 1'b0, 16'h1300, 2);
        t_mem(3'h3, 2'h1, 16'h00ff, 1'b0, 16'h1ffd, 1);
        t_mem(3'h2, 2'h1, 16'h0001, 1'b1, 16'h2301, 3);
        t_blk(OAG_MODE_BLOCK_SRC, 1'b0, 1'b0, 16'h0001);
        t_blk(OAG_MODE_BLOCK_DST, 1'b1, 1'b0, 16'h0005);
        t_blk(OAG_MODE_BLOCK_SRC, 1'b1, 1'b1, 16'h0002);
        t_blk(OAG_MODE_BLOCK_DST, 1'b0, 1'b1, 16'h0001);
        t_branch(1'b0, 16'h4321);
        t_branch(1'b1, 16'h8ace);
        end_of_test;
    end
endmodule
bind oag_top oag_chk chk_u (.*);
